// ### branch_and_bit_ops_decoder.sv
// Purpose: executes skip, conditional branch, I/O bit set/clear, rotate and bit transfer instructions
// Assumes: fetch presents one instruction with instrValid while busy is low; I/O read data is same-cycle
// Notes: the block owns the program counter and the status flags for this slice
`timescale 1ns/1ps
`default_nettype none
module branch_and_bit_ops_decoder (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// instruction from fetch
	input wire logic instrValid,
	input wire branch_bit_pkg::instr_type instr,
	// operand reads
	input wire logic [branch_bit_pkg::DATA_W-1:0] ioReadData,
	input wire logic [branch_bit_pkg::DATA_W-1:0] regReadData,
	// flag load from other units
	input wire logic flagsLoad,
	input wire logic [branch_bit_pkg::DATA_W-1:0] flagsIn,
	// state and writes out
	output logic busy,
	output logic [branch_bit_pkg::PC_W-1:0] pc,
	output logic [branch_bit_pkg::DATA_W-1:0] statusFlags,
	output branch_bit_pkg::write_type writes,
	output logic [1:0] lastCycles
);
	import branch_bit_pkg::*;

	logic isBranch;
	logic taken;
	state_type state, next_state;
	logic [PC_W-1:0] next_pc;
	logic [DATA_W-1:0] next_statusFlags;
	write_type next_writes;
	logic [1:0] next_lastCycles;
	logic [1:0] waitLeft, next_waitLeft;
	logic [DATA_W-1:0] pendingIo, next_pendingIo;
	logic [IO_ADDR_W-1:0] pendingAddr, next_pendingAddr;
	logic [PC_W-1:0] offsetExt;
	logic [DATA_W-1:0] rotated;
	logic rotCarry;
	logic accept;
	logic ioBitSet;
	logic next_busy;

	branch_condition cond (
		.op(instr.op),
		.bitSel(instr.bitSel),
		.flags(statusFlags),
		.isBranch(isBranch),
		.taken(taken)
	);

	// sign-extend the word offset so backward branches wrap correctly
	assign offsetExt = {{(PC_W-OFFSET_W){instr.offset[OFFSET_W-1]}}, instr.offset};
	assign accept = instrValid && (state == ST_IDLE);
	// skip test reads the I/O value in the accept cycle; no stale copy is kept
	assign ioBitSet = ioReadData[instr.bitSel];

	// both rotate directions share one result path; the carry leaves from the far end
	always_comb begin
		if (instr.op == OP_ROTATE_LEFT_THROUGH_CARRY) begin
			rotated = {regReadData[DATA_W-2:0], statusFlags[FLAG_C]};
			rotCarry = regReadData[DATA_W-1];
		end else begin
			rotated = {statusFlags[FLAG_C], regReadData[DATA_W-1:1]};
			rotCarry = regReadData[0];
		end
	end

	// sequencing: program counter, cycle cost and the dead cycles after a change of flow
	always_comb begin
		next_state = state;
		next_pc = pc;
		next_lastCycles = lastCycles;
		next_waitLeft = waitLeft;
		case (state)
			ST_IDLE: begin
				if (accept) begin
					next_pc = pc + STEP_ONE;
					next_lastCycles = CYCLES_ONE;
					if (isBranch && taken) begin
						// the refetch after a taken branch is the extra cycle
						next_pc = pc + STEP_ONE + offsetExt;
						next_lastCycles = CYCLES_TWO;
						next_waitLeft = CYCLES_ONE;
						next_state = ST_WAIT;
					end
					case (instr.op)
						OP_SKIP_IF_IO_BIT_SET: begin
							if (ioBitSet) begin
								// skipping a two-word instruction costs one extra cycle
								next_pc = pc + (instr.nextIsLong ? STEP_THREE : STEP_TWO);
								next_lastCycles = instr.nextIsLong ? CYCLES_THREE : CYCLES_TWO;
								next_waitLeft = instr.nextIsLong ? CYCLES_TWO : CYCLES_ONE;
								next_state = ST_WAIT;
							end
						end
						OP_SET_IO_BIT, OP_CLEAR_IO_BIT: begin
							next_lastCycles = CYCLES_TWO;
							next_state = ST_IO_WRITE;
						end
						default: begin
						end
					endcase
				end
			end
			ST_WAIT: begin
				// dead cycles while fetch refills after a change of flow
				next_waitLeft = waitLeft - 2'h1;
				if (waitLeft == CYCLES_ONE) begin
					next_state = ST_IDLE;
				end
			end
			ST_IO_WRITE: begin
				next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
		// busy is a flop so fetch sees a clean stall from the cycle after acceptance
		next_busy = (next_state != ST_IDLE);
	end

	// sequencing registers
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state <= ST_IDLE;
			pc <= PC_RESET;
			lastCycles <= '0;
			waitLeft <= '0;
			busy <= 1'b0;
		end else begin
			state <= next_state;
			pc <= next_pc;
			lastCycles <= next_lastCycles;
			waitLeft <= next_waitLeft;
			busy <= next_busy;
		end
	end

	// status flags: an instruction's own flag result overrides a load from elsewhere in the same cycle
	always_comb begin
		next_statusFlags = statusFlags;
		if (flagsLoad) begin
			next_statusFlags = flagsIn;
		end
		if (accept) begin
			case (instr.op)
				OP_ROTATE_LEFT_THROUGH_CARRY, OP_ROTATE_RIGHT_THROUGH_CARRY: begin
					next_statusFlags[FLAG_C] = rotCarry;
					next_statusFlags[FLAG_Z] = (rotated == '0);
					next_statusFlags[FLAG_N] = rotated[DATA_W-1];
					// overflow is N xor new carry; S follows N xor V
					next_statusFlags[FLAG_V] = rotated[DATA_W-1] ^ rotCarry;
					next_statusFlags[FLAG_S] = rotated[DATA_W-1] ^ next_statusFlags[FLAG_V];
				end
				OP_BIT_STORE_TO_TRANSFER_FLAG: begin
					next_statusFlags[FLAG_T] = regReadData[instr.bitSel];
				end
				default: begin
				end
			endcase
		end
	end

	// status flag register; branches, skips and I/O bit writes never touch it
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			statusFlags <= FLAGS_RESET;
		end else begin
			statusFlags <= next_statusFlags;
		end
	end

	// write pulses: register results in the accept cycle, the I/O write one cycle later
	always_comb begin
		next_writes = '0;
		next_pendingIo = pendingIo;
		next_pendingAddr = pendingAddr;
		if (accept) begin
			case (instr.op)
				OP_SET_IO_BIT, OP_CLEAR_IO_BIT: begin
					// read-modify-write: only the addressed bit changes
					next_pendingIo = ioReadData;
					next_pendingIo[instr.bitSel] = (instr.op == OP_SET_IO_BIT);
					next_pendingAddr = instr.ioAddr;
				end
				OP_ROTATE_LEFT_THROUGH_CARRY, OP_ROTATE_RIGHT_THROUGH_CARRY: begin
					next_writes.regWrite = 1'b1;
					next_writes.regAddr = instr.regAddr;
					next_writes.regData = rotated;
				end
				OP_BIT_LOAD_FROM_TRANSFER_FLAG: begin
					next_writes.regWrite = 1'b1;
					next_writes.regAddr = instr.regAddr;
					next_writes.regData = regReadData;
					next_writes.regData[instr.bitSel] = statusFlags[FLAG_T];
				end
				default: begin
				end
			endcase
		end
		// the held value goes out in the second cycle; the target is not read again, so a change in between is lost
		if (state == ST_IO_WRITE) begin
			next_writes.ioWrite = 1'b1;
			next_writes.ioAddr = pendingAddr;
			next_writes.ioData = pendingIo;
		end
	end

	// write and pending registers; a reset drops a pending I/O write
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			writes <= '0;
			pendingIo <= '0;
			pendingAddr <= '0;
		end else begin
			writes <= next_writes;
			pendingIo <= next_pendingIo;
			pendingAddr <= next_pendingAddr;
		end
	end
endmodule
`default_nettype wire

// ### branch_and_bit_ops_decoder_props.sv
// Purpose: port-level checks for the branch and bit-operation slice
// Assumes: one clock domain, asynchronous active-low reset
// Notes: each check except a_busy_hold is judged one or more edges after acceptance; a_busy_hold is judged one edge after any busy cycle
`timescale 1ns/1ps
`default_nettype none
module branch_and_bit_ops_decoder_props (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// inputs
	input wire logic instrValid,
	input wire branch_bit_pkg::instr_type instr,
	input wire logic [branch_bit_pkg::DATA_W-1:0] ioReadData,
	input wire logic [branch_bit_pkg::DATA_W-1:0] regReadData,
	input wire logic flagsLoad,
	input wire logic [branch_bit_pkg::DATA_W-1:0] flagsIn,
	// outputs
	input wire logic busy,
	input wire logic [branch_bit_pkg::PC_W-1:0] pc,
	input wire logic [branch_bit_pkg::DATA_W-1:0] statusFlags,
	input wire branch_bit_pkg::write_type writes,
	input wire logic [1:0] lastCycles
);
	import branch_bit_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// an instruction counts only where busy lets it in
	wire logic acc;
	assign acc = instrValid && !busy;
	a_eq_taken: assert property (acc && instr.op == OP_BRANCH_IF_EQUAL && statusFlags[FLAG_Z] |=>
		busy && lastCycles == CYCLES_TWO && pc == $past(pc) + STEP_ONE + {{9{$past(instr.offset[6])}}, $past(instr.offset)})
		else $error("equal branch not taken right");
	a_ne_falls: assert property (acc && instr.op == OP_BRANCH_IF_NOT_EQUAL && statusFlags[FLAG_Z] |=>
		!busy && pc == $past(pc) + STEP_ONE) else $error("not-equal branch did not fall through");
	a_skip_long: assert property (acc && instr.op == OP_SKIP_IF_IO_BIT_SET && ioReadData[instr.bitSel]
		&& instr.nextIsLong |=> (busy && pc == $past(pc) + STEP_THREE) ##1 busy ##1 !busy) else $error("long skip wrong");
	a_set_io: assert property (acc && instr.op == OP_SET_IO_BIT |=> busy ##1 (!busy && writes.ioWrite
		&& writes.ioData == ($past(ioReadData, 2) | (8'h01 << $past(instr.bitSel, 2))))) else $error("set io bit wrong");
	a_clear_io: assert property (acc && instr.op == OP_CLEAR_IO_BIT |=> busy ##1 (!busy && writes.ioWrite
		&& writes.ioData == ($past(ioReadData, 2) & ~(8'h01 << $past(instr.bitSel, 2))))) else $error("clear io bit wrong");
	a_rol_data: assert property (acc && instr.op == OP_ROTATE_LEFT_THROUGH_CARRY |=> writes.regWrite
		&& writes.regData == {$past(regReadData[6:0]), $past(statusFlags[FLAG_C])}
		&& statusFlags[FLAG_C] == $past(regReadData[7])) else $error("rotate left wrong");
	a_ror_data: assert property (acc && instr.op == OP_ROTATE_RIGHT_THROUGH_CARRY |=> writes.regWrite
		&& writes.regData == {$past(statusFlags[FLAG_C]), $past(regReadData[7:1])}
		&& statusFlags[FLAG_C] == $past(regReadData[0])) else $error("rotate right wrong");
	a_bst_flag: assert property (acc && instr.op == OP_BIT_STORE_TO_TRANSFER_FLAG |=>
		statusFlags[FLAG_T] == $past(regReadData[instr.bitSel])) else $error("bit store wrong");
	a_bld_bit: assert property (acc && instr.op == OP_BIT_LOAD_FROM_TRANSFER_FLAG |=> writes.regWrite
		&& writes.regData[$past(instr.bitSel)] == $past(statusFlags[FLAG_T])) else $error("bit load wrong");
	a_busy_hold: assert property (busy |=> $stable(pc)) else $error("pc moved while busy");
endmodule
bind branch_and_bit_ops_decoder branch_and_bit_ops_decoder_props props (.ref_clk(ref_clk), .rstn(rstn),
	.instrValid(instrValid), .instr(instr), .ioReadData(ioReadData), .regReadData(regReadData), .flagsLoad(flagsLoad),
	.flagsIn(flagsIn), .busy(busy), .pc(pc), .statusFlags(statusFlags), .writes(writes), .lastCycles(lastCycles));
`default_nettype wire

// ### branch_bit_pkg.sv
// Purpose: shared types and constants for the branch and bit-operation decode slice
// Assumes: 16-bit instruction words, 8-bit data, flags ordered I T H S V N Z C (bit 7..0)
// Notes: opcode encodings are local to this slice; the fetch stage maps its words onto them
package branch_bit_pkg;
	localparam int DATA_W = 8;
	localparam int PC_W = 16;
	localparam int IO_ADDR_W = 5;
	localparam int REG_ADDR_W = 5;
	localparam int OFFSET_W = 7;
	// status flag bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;
	// values after reset
	localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;
	// cycle counts
	localparam logic [1:0] CYCLES_ONE = 2'h1;
	localparam logic [1:0] CYCLES_TWO = 2'h2;
	localparam logic [1:0] CYCLES_THREE = 2'h3;
	// word steps
	localparam logic [PC_W-1:0] STEP_ONE = 16'h0001;
	localparam logic [PC_W-1:0] STEP_TWO = 16'h0002;
	localparam logic [PC_W-1:0] STEP_THREE = 16'h0003;

	typedef enum logic [4:0] {
		OP_NONE = 5'h00,
		OP_SKIP_IF_IO_BIT_SET = 5'h01,
		OP_BRANCH_ON_STATUS_BIT_SET = 5'h02,
		OP_BRANCH_ON_STATUS_BIT_CLEAR = 5'h03,
		OP_BRANCH_IF_EQUAL = 5'h04,
		OP_BRANCH_IF_NOT_EQUAL = 5'h05,
		OP_BRANCH_IF_CARRY_SET = 5'h06,
		OP_BRANCH_IF_CARRY_CLEAR = 5'h07,
		OP_BRANCH_IF_SAME_OR_HIGHER = 5'h08,
		OP_BRANCH_IF_LOWER = 5'h09,
		OP_BRANCH_IF_MINUS = 5'h0A,
		OP_BRANCH_IF_PLUS = 5'h0B,
		OP_BRANCH_IF_GREATER_EQUAL_SIGNED = 5'h0C,
		OP_BRANCH_IF_LESS_SIGNED = 5'h0D,
		OP_BRANCH_IF_HALF_CARRY_SET = 5'h0E,
		OP_BRANCH_IF_HALF_CARRY_CLEAR = 5'h0F,
		OP_BRANCH_IF_OVERFLOW_CLEAR = 5'h10,
		OP_BRANCH_IF_INTERRUPTS_ENABLED = 5'h11,
		OP_SET_IO_BIT = 5'h12,
		OP_CLEAR_IO_BIT = 5'h13,
		OP_ROTATE_LEFT_THROUGH_CARRY = 5'h14,
		OP_ROTATE_RIGHT_THROUGH_CARRY = 5'h15,
		OP_BIT_STORE_TO_TRANSFER_FLAG = 5'h16,
		OP_BIT_LOAD_FROM_TRANSFER_FLAG = 5'h17
	} opcode_type;

	// one decoded instruction from fetch
	typedef struct packed {
		opcode_type op;
		logic [2:0] bitSel;
		logic [IO_ADDR_W-1:0] ioAddr;
		logic [REG_ADDR_W-1:0] regAddr;
		logic [OFFSET_W-1:0] offset;
		logic nextIsLong;
	} instr_type;

	// write request toward the I/O space or the register file
	typedef struct packed {
		logic ioWrite;
		logic [IO_ADDR_W-1:0] ioAddr;
		logic [DATA_W-1:0] ioData;
		logic regWrite;
		logic [REG_ADDR_W-1:0] regAddr;
		logic [DATA_W-1:0] regData;
	} write_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_IO_WRITE = 3'b100
	} state_type;
endpackage

// ### branch_condition.sv
// Purpose: evaluates whether a conditional branch is taken
// Assumes: flags follow the package bit layout
// Notes: pure combinational; the caller registers the result
`timescale 1ns/1ps
`default_nettype none
module branch_condition (
	// decoded operation
	input wire branch_bit_pkg::opcode_type op,
	input wire logic [2:0] bitSel,
	// current status flags
	input wire logic [7:0] flags,
	// result
	output logic isBranch,
	output logic taken
);
	import branch_bit_pkg::*;

	// condition per opcode; the named forms are fixed-bit cases of the generic ones, except the signed pair, which tests N xor V rather than S
	always_comb begin
		isBranch = 1'b1;
		taken = 1'b0;
		case (op)
			OP_BRANCH_ON_STATUS_BIT_SET: taken = flags[bitSel];
			OP_BRANCH_ON_STATUS_BIT_CLEAR: taken = ~flags[bitSel];
			OP_BRANCH_IF_EQUAL: taken = flags[FLAG_Z];
			OP_BRANCH_IF_NOT_EQUAL: taken = ~flags[FLAG_Z];
			OP_BRANCH_IF_CARRY_SET, OP_BRANCH_IF_LOWER: taken = flags[FLAG_C];
			OP_BRANCH_IF_CARRY_CLEAR, OP_BRANCH_IF_SAME_OR_HIGHER: taken = ~flags[FLAG_C];
			OP_BRANCH_IF_MINUS: taken = flags[FLAG_N];
			OP_BRANCH_IF_PLUS: taken = ~flags[FLAG_N];
			OP_BRANCH_IF_GREATER_EQUAL_SIGNED: taken = ~(flags[FLAG_N] ^ flags[FLAG_V]);
			OP_BRANCH_IF_LESS_SIGNED: taken = flags[FLAG_N] ^ flags[FLAG_V];
			OP_BRANCH_IF_HALF_CARRY_SET: taken = flags[FLAG_H];
			OP_BRANCH_IF_HALF_CARRY_CLEAR: taken = ~flags[FLAG_H];
			OP_BRANCH_IF_OVERFLOW_CLEAR: taken = ~flags[FLAG_V];
			OP_BRANCH_IF_INTERRUPTS_ENABLED: taken = flags[FLAG_I];
			default: isBranch = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// ### tb_branch_and_bit_ops_decoder.sv
// Purpose: directed bench for the branch and bit-operation slice
// Assumes: inputs change at rising edges by non-blocking assignment
// Notes: expected pc and flags are tracked here, never read back
`timescale 1ns/1ps
`default_nettype none
module tb_branch_and_bit_ops_decoder;
	import branch_bit_pkg::*;
	// stimulus, observation and tallies
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic instrValid = 1'b0;
	instr_type instr = '0;
	logic [7:0] ioReadData = 8'h00;
	logic [7:0] regReadData = 8'h00;
	logic flagsLoad = 1'b0;
	logic [7:0] flagsIn = 8'h00;
	logic busy;
	logic [15:0] pc;
	logic [7:0] statusFlags;
	write_type writes;
	logic [1:0] lastCycles;
	int errors = 0;
	int checks = 0;
	logic [15:0] expPc = PC_RESET;
	logic [7:0] expF = FLAGS_RESET;
	branch_and_bit_ops_decoder dut (.ref_clk(ref_clk), .rstn(rstn), .instrValid(instrValid), .instr(instr),
		.ioReadData(ioReadData), .regReadData(regReadData), .flagsLoad(flagsLoad), .flagsIn(flagsIn),
		.busy(busy), .pc(pc), .statusFlags(statusFlags), .writes(writes), .lastCycles(lastCycles));
	// 50 ns period
	initial begin
		forever #25 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		if (errors == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// hold one instruction for one edge, then let that edge land
	task automatic issue(input opcode_type o, input logic [2:0] b, input logic [6:0] k, input logic l,
		input logic [7:0] io, input logic [7:0] rg);
		@(posedge ref_clk);
		instrValid <= 1'b1;
		instr <= '{op: o, bitSel: b, ioAddr: 5'h03, regAddr: 5'h07, offset: k, nextIsLong: l};
		ioReadData <= io;
		regReadData <= rg;
		@(posedge ref_clk);
		instrValid <= 1'b0;
		#1;
	endtask
	// bounded wait so a stuck busy cannot hang the run
	task automatic idle();
		for (int i = 0; i < 4 && busy !== 1'b0; i++) begin
			@(posedge ref_clk);
			#1;
		end
	endtask
	task automatic setF(input logic [7:0] f);
		@(posedge ref_clk);
		flagsLoad <= 1'b1;
		flagsIn <= f;
		@(posedge ref_clk);
		flagsLoad <= 1'b0;
		expF = f;
	endtask
	function automatic logic expTaken(input opcode_type o, input logic [2:0] b, input logic [7:0] f);
		case (o)
			OP_BRANCH_ON_STATUS_BIT_SET: return f[b];
			OP_BRANCH_ON_STATUS_BIT_CLEAR: return !f[b];
			OP_BRANCH_IF_EQUAL: return f[FLAG_Z];
			OP_BRANCH_IF_NOT_EQUAL: return !f[FLAG_Z];
			OP_BRANCH_IF_CARRY_SET, OP_BRANCH_IF_LOWER: return f[FLAG_C];
			OP_BRANCH_IF_CARRY_CLEAR, OP_BRANCH_IF_SAME_OR_HIGHER: return !f[FLAG_C];
			OP_BRANCH_IF_MINUS: return f[FLAG_N];
			OP_BRANCH_IF_PLUS: return !f[FLAG_N];
			OP_BRANCH_IF_GREATER_EQUAL_SIGNED: return !(f[FLAG_N] ^ f[FLAG_V]);
			OP_BRANCH_IF_LESS_SIGNED: return f[FLAG_N] ^ f[FLAG_V];
			OP_BRANCH_IF_HALF_CARRY_SET: return f[FLAG_H];
			OP_BRANCH_IF_HALF_CARRY_CLEAR: return !f[FLAG_H];
			OP_BRANCH_IF_OVERFLOW_CLEAR: return !f[FLAG_V];
			OP_BRANCH_IF_INTERRUPTS_ENABLED: return f[FLAG_I];
			default: return 1'b0;
		endcase
	endfunction
	// every branch under four flag patterns, forward and backward offsets
	task automatic tBranches();
		logic [7:0] pat [4] = '{8'h00, 8'hFF, 8'h28, 8'hC4};
		logic t;
		logic [6:0] k;
		logic [1:0] ec;
		for (int i = 2; i < 18; i++) begin
			for (int j = 0; j < 4; j++) begin
				setF(pat[j]);
				t = expTaken(opcode_type'(5'(i)), 3'(i + j), pat[j]);
				k = j[0] ? 7'h7D : 7'h05;
				issue(opcode_type'(5'(i)), 3'(i + j), k, 1'b0, 8'h00, 8'h00);
				expPc = t ? expPc + STEP_ONE + {{9{k[6]}}, k} : expPc + STEP_ONE;
				ec = t ? CYCLES_TWO : CYCLES_ONE;
				chk({pc, statusFlags, busy, lastCycles}, {expPc, expF, t, ec});
				idle();
			end
		end
	endtask
	// bit clear, set with short next, set with long next
	task automatic tSkip();
		for (int c = 0; c < 3; c++) begin
			issue(OP_SKIP_IF_IO_BIT_SET, 3'h4, 7'h00, c == 2, c == 0 ? 8'hEF : 8'h10, 8'h00);
			expPc = expPc + 16'(c + 1);
			chk({pc, statusFlags, 5'h00, busy, lastCycles}, {expPc, expF, 5'h00, c != 0, 2'(c + 1)});
			idle();
		end
	endtask
	// read-modify-write lands one edge after acceptance
	task automatic tIo();
		logic [7:0] ed;
		for (int c = 0; c < 2; c++) begin
			ed = c ? 8'h58 : 8'h5B;
			issue(c ? OP_CLEAR_IO_BIT : OP_SET_IO_BIT, 3'(c), 7'h00, 1'b0, 8'h5A, 8'h00);
			expPc = expPc + STEP_ONE;
			chk({pc, statusFlags, 5'h00, busy, lastCycles}, {expPc, expF, 5'h00, 1'b1, CYCLES_TWO});
			@(posedge ref_clk);
			#1;
			chk({writes.ioWrite, writes.ioAddr, writes.ioData, statusFlags, busy}, {1'b1, 5'h03, ed, expF, 1'b0});
		end
	endtask
	// single-cycle register ops; w says whether a register write is due
	task automatic xop(input opcode_type o, input logic [2:0] b, input logic [7:0] d, input logic w,
		input logic [7:0] ed, input logic [7:0] ef);
		issue(o, b, 7'h00, 1'b0, 8'h00, d);
		expPc = expPc + STEP_ONE;
		chk({pc, statusFlags, busy, lastCycles}, {expPc, ef, 1'b0, CYCLES_ONE});
		chk({writes.regWrite, writes.regAddr, writes.regData}, {w, w ? 5'h07 : 5'h00, ed});
	endtask
	// a request during busy is ignored; a reset in mid-instruction drops the dead cycles
	task automatic tRefuseReset();
		issue(OP_SKIP_IF_IO_BIT_SET, 3'h1, 7'h00, 1'b1, 8'h02, 8'h00);
		expPc = expPc + STEP_THREE;
		issue(OP_BRANCH_IF_EQUAL, 3'h0, 7'h10, 1'b0, 8'h00, 8'h00);
		chk({pc, busy, lastCycles}, {expPc, 1'b0, CYCLES_THREE});
		issue(OP_SKIP_IF_IO_BIT_SET, 3'h1, 7'h00, 1'b1, 8'h02, 8'h00);
		chk({pc, busy}, {expPc + STEP_THREE, 1'b1});
		@(posedge ref_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		#1;
		chk({pc, statusFlags, writes.regWrite, busy, lastCycles}, {PC_RESET, FLAGS_RESET, 4'h0});
		expPc = PC_RESET;
		issue(OP_SKIP_IF_IO_BIT_SET, 3'h1, 7'h00, 1'b1, 8'hFD, 8'h00);
		expPc = expPc + STEP_ONE;
		chk({pc, statusFlags, busy, lastCycles}, {expPc, FLAGS_RESET, 1'b0, CYCLES_ONE});
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		rstn <= 1'b1;
		#1;
		chk({pc, statusFlags, writes.ioWrite, writes.regWrite, busy, lastCycles}, {PC_RESET, FLAGS_RESET, 5'h00});
		tBranches();
		tSkip();
		tIo();
		setF(8'h01);
		xop(OP_ROTATE_LEFT_THROUGH_CARRY, 3'h0, 8'h80, 1'b1, 8'h01, 8'h19);
		xop(OP_ROTATE_RIGHT_THROUGH_CARRY, 3'h0, 8'h01, 1'b1, 8'h80, 8'h15);
		setF(8'h00);
		xop(OP_ROTATE_RIGHT_THROUGH_CARRY, 3'h0, 8'h01, 1'b1, 8'h00, 8'h1B);
		xop(OP_BIT_STORE_TO_TRANSFER_FLAG, 3'h5, 8'h20, 1'b0, 8'h00, 8'h5B);
		xop(OP_BIT_LOAD_FROM_TRANSFER_FLAG, 3'h3, 8'h00, 1'b1, 8'h08, 8'h5B);
		xop(OP_BIT_STORE_TO_TRANSFER_FLAG, 3'h5, 8'hDF, 1'b0, 8'h00, 8'h1B);
		tRefuseReset();
		conclude();
	end
	// generous against the few hundred edges the tests need
	initial begin
		repeat (3000) @(posedge ref_clk);
		errors++;
		conclude();
	end
endmodule
`default_nettype wire
